// ### rtl/bfg_pkg.sv
// constants, register map and state encoding of the boot flash access guard
// assumes a single pclk domain and a 32-bit apb register port
`default_nettype none

package bfg_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned LOCK_OP_CYCLES = 1;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_POINTER = 8'h04;
  localparam logic [7:0] OFF_LOCK_DATA = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_LOCKS = 8'h10;

  // ----------------------------------------------------------------
  // command register fields
  // ----------------------------------------------------------------
  localparam int unsigned CMD_LSB = 0;
  localparam int unsigned CMD_RESUME_BIT = 4;
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_ERASE = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  localparam logic [1:0] CMD_LOCK = 2'h3;

  // ----------------------------------------------------------------
  // status bits
  // ----------------------------------------------------------------
  localparam int unsigned STB_BUSY = 0;
  localparam int unsigned STB_REGION_BUSY = 1;
  localparam int unsigned STB_HALT = 2;
  localparam int unsigned STB_BLOCKED = 3;

  // ----------------------------------------------------------------
  // lock field layout, 1 means unprogrammed
  // ----------------------------------------------------------------
  localparam int unsigned LK_APP_LOWER = 0;
  localparam int unsigned LK_APP_UPPER = 1;
  localparam int unsigned LK_LDR_LOWER = 2;
  localparam int unsigned LK_LDR_UPPER = 3;
  localparam logic [3:0] LOCK_RESET = 4'hf;

  // ----------------------------------------------------------------
  // vectors and states
  // ----------------------------------------------------------------
  localparam logic [14:0] APP_RESET_VECTOR = 15'h0000;

  typedef enum logic [1:0] {
    BFG_IDLE = 2'b00,
    BFG_BUSY = 2'b01
  } bfg_state_t;

endpackage : bfg_pkg

`default_nettype wire

// ### rtl/bfg_top.sv
// boot flash access guard: region stalling, lock checks, pointer latching
// assumes the cpu core reports store and load instructions as one-cycle pulses
// with the word address of the executing code, and apb from the same core
//
// Notes on behaviour
// - op on concurrent region: cpu runs, stalling region stays readable
// - op on stalling region: cpu halted, nothing readable until done
// - two lock fields, application and loader, set independently
// - locks only programmed by software or external port; chip erase clears
// - general write lock never gates store-instruction programming
// - general read/write lock never gates loads or stores
// - app lock 1,1 no limit; 1,0 blocks stores to application region
// - app lock 0,0 blocks stores and loader-code loads of application region
// - app lock 0,1 allows stores, blocks loader-code loads of application
// - load-blocking app modes mask interrupts in app code if vectors in loader
// - loader lock 1,1 no limit; 1,0 blocks stores to loader region
// - loader lock 0,0 blocks stores and app-code loads of loader region
// - loader lock 0,1 allows stores, blocks app-code loads of loader region
// - load-blocking loader modes mask interrupts in loader code if vectors in app
// - reset vector 0x0000 when fuse reads 1, loader start when 0
// - cpu cannot alter fuses; only external programming changes them
// - address from 16-bit pointer: low bits word in page, high bits page
// - target page latched at op start; later pointer writes have no effect
// - lock setting ignores the pointer completely
// - loads address flash bytewise, pointer bit 0 picks the byte
// - store programming starts only from loader code, may target any address
// - region busy flag reads one while concurrent region is blocked
`default_nettype none

module bfg_top #(
  parameter int unsigned PAGE_LOG2 = 6,
  parameter logic [14:0] LOADER_START = 15'h1c00,
  parameter logic [14:0] STALL_START = 15'h1c00,
  parameter int unsigned PROG_TIME_NS = 4000000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [14:0] cpu_pc,
  input wire logic flash_store_instr,
  input wire logic load_req,
  input wire logic ivec_in_loader,
  input wire logic reset_vector_select_fuse,
  input wire logic ext_lock_prog,
  input wire logic [3:0] ext_lock_data,
  input wire logic chip_erase,
  output logic cpu_halt,
  output logic concurrent_read_ok,
  output logic stalling_read_ok,
  output logic flash_op_start,
  output logic [1:0] flash_op_kind,
  output logic [14:0] flash_op_page_addr,
  output logic load_valid,
  output logic load_grant,
  output logic [15:0] load_byte_addr,
  output logic irq_disable,
  output logic [14:0] reset_vector
);

  // ----------------------------------------------------------------
  // derived constants
  // ----------------------------------------------------------------
  localparam int unsigned PROG_RAW =
    (PROG_TIME_NS + bfg_pkg::CLK_PERIOD_NS - 1) / bfg_pkg::CLK_PERIOD_NS;
  localparam int unsigned PROG_CYCLES = (PROG_RAW < 1) ? 1 : PROG_RAW;
  localparam logic [31:0] PROG_LOAD = 32'(PROG_CYCLES - 1);

  typedef struct packed {
    bfg_pkg::bfg_state_t st;
    logic [1:0] cmd;
    logic [15:0] ptr;
    logic [3:0] lock_data;
    logic [3:0] locks;
    logic [31:0] cnt;
    logic op_stall;
    logic region_busy;
    logic blocked;
    logic halt;
    logic stall_ok;
    logic op_start;
    logic [1:0] op_kind;
    logic [14:0] op_page;
    logic ld_valid;
    logic ld_grant;
    logic [15:0] ld_addr;
    logic irq_dis;
    logic fuse_seen;
    logic [14:0] rst_vec;
    logic [31:0] rdata;
    logic rdy;
    logic err;
  } bfg_state_vec_t;

  bfg_state_vec_t s_ff;
  bfg_state_vec_t nxt_s;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  logic acc;
  logic mapped;
  logic from_ldr;
  logic [14:0] tgt_word;
  logic tgt_ldr;
  logic ld_tgt_ldr;
  logic st_blocked;
  logic ld_blocked;
  logic ld_unreadable;

  assign acc = psel & penable & s_ff.rdy;
  assign mapped = (paddr == bfg_pkg::OFF_CMD) | (paddr == bfg_pkg::OFF_POINTER) |
                  (paddr == bfg_pkg::OFF_LOCK_DATA) | (paddr == bfg_pkg::OFF_STATUS) |
                  (paddr == bfg_pkg::OFF_LOCKS);
  assign from_ldr = cpu_pc >= LOADER_START;
  // page bits of the pointer with word bits forced to zero
  assign tgt_word = {s_ff.ptr[15:PAGE_LOG2+1], PAGE_LOG2'(0)};
  assign tgt_ldr = tgt_word >= LOADER_START;
  assign ld_tgt_ldr = s_ff.ptr[15:1] >= LOADER_START;
  // stores blocked when the region's lower lock bit is programmed
  assign st_blocked = tgt_ldr ? ~s_ff.locks[bfg_pkg::LK_LDR_LOWER]
                              : ~s_ff.locks[bfg_pkg::LK_APP_LOWER];
  // cross-region loads blocked when the upper lock bit is programmed
  assign ld_blocked = (from_ldr & ~ld_tgt_ldr & ~s_ff.locks[bfg_pkg::LK_APP_UPPER]) |
                      (~from_ldr & ld_tgt_ldr & ~s_ff.locks[bfg_pkg::LK_LDR_UPPER]);
  // general lock modes are deliberately not part of either check
  assign ld_unreadable = (s_ff.st == bfg_pkg::BFG_BUSY & s_ff.op_stall) |
                         (s_ff.region_busy & (s_ff.ptr[15:1] < STALL_START));

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.op_start = 1'b0;
    nxt_s.ld_valid = 1'b0;
    // apb: zero-wait access phase, error on unmapped offsets
    nxt_s.rdy = psel & ~penable;
    nxt_s.err = psel & ~penable & ~mapped;
    nxt_s.rdata = 32'h0000_0000;
    if (psel & ~penable & ~pwrite) begin
      case (paddr)
        bfg_pkg::OFF_CMD: nxt_s.rdata = {30'h0000_0000, s_ff.cmd};
        bfg_pkg::OFF_POINTER: nxt_s.rdata = {16'h0000, s_ff.ptr};
        bfg_pkg::OFF_LOCK_DATA: nxt_s.rdata = {28'h000_0000, s_ff.lock_data};
        bfg_pkg::OFF_STATUS: nxt_s.rdata = {28'h000_0000, s_ff.blocked, s_ff.halt,
                                            s_ff.region_busy,
                                            s_ff.st == bfg_pkg::BFG_BUSY};
        bfg_pkg::OFF_LOCKS: nxt_s.rdata = {28'h000_0000, s_ff.locks};
        default: nxt_s.rdata = 32'h0000_0000;
      endcase
    end
    // apb writes; pointer may change freely while an op runs
    if (acc & pwrite) begin
      case (paddr)
        bfg_pkg::OFF_POINTER: nxt_s.ptr = pwdata[15:0];
        bfg_pkg::OFF_LOCK_DATA: nxt_s.lock_data = pwdata[3:0];
        bfg_pkg::OFF_CMD: begin
          if (s_ff.st == bfg_pkg::BFG_IDLE) begin
            nxt_s.cmd = pwdata[bfg_pkg::CMD_LSB +: 2];
            if (pwdata[bfg_pkg::CMD_RESUME_BIT]) begin
              nxt_s.region_busy = 1'b0;
            end
          end
        end
        default: nxt_s.blocked = s_ff.blocked;
      endcase
    end
    // store instruction sequencing
    case (s_ff.st)
      bfg_pkg::BFG_IDLE: begin
        if (flash_store_instr & from_ldr & (s_ff.cmd != bfg_pkg::CMD_NONE)) begin
          nxt_s.cmd = bfg_pkg::CMD_NONE;
          if (s_ff.cmd == bfg_pkg::CMD_LOCK) begin
            // programs zeros only; pointer plays no part
            nxt_s.locks = nxt_s.locks & s_ff.lock_data;
            nxt_s.blocked = 1'b0;
          end else if (st_blocked) begin
            nxt_s.blocked = 1'b1;
          end else begin
            nxt_s.st = bfg_pkg::BFG_BUSY;
            nxt_s.cnt = PROG_LOAD;
            nxt_s.op_start = 1'b1;
            nxt_s.op_kind = s_ff.cmd;
            nxt_s.op_page = tgt_word;
            nxt_s.op_stall = tgt_word >= STALL_START;
            nxt_s.halt = tgt_word >= STALL_START;
            nxt_s.stall_ok = tgt_word < STALL_START;
            nxt_s.region_busy = 1'b1;
            nxt_s.blocked = 1'b0;
          end
        end
      end
      bfg_pkg::BFG_BUSY: begin
        if (s_ff.cnt == 32'h0000_0000) begin
          nxt_s.st = bfg_pkg::BFG_IDLE;
          nxt_s.halt = 1'b0;
          nxt_s.stall_ok = 1'b1;
          nxt_s.op_stall = 1'b0;
        end else begin
          nxt_s.cnt = s_ff.cnt - 32'h0000_0001;
        end
      end
      default: nxt_s.st = bfg_pkg::BFG_IDLE;
    endcase
    // external programming port; apart from reset, chip erase alone returns locks to ones
    if (chip_erase) begin
      nxt_s.locks = bfg_pkg::LOCK_RESET;
    end
    if (ext_lock_prog) begin
      nxt_s.locks = nxt_s.locks & ext_lock_data;
    end
    // program-memory loads, answered one cycle later
    if (load_req) begin
      nxt_s.ld_valid = 1'b1;
      nxt_s.ld_grant = ~ld_blocked & ~ld_unreadable;
      nxt_s.ld_addr = s_ff.ptr;
    end
    // interrupt masking for load-blocking lock modes
    nxt_s.irq_dis = (~s_ff.locks[bfg_pkg::LK_APP_UPPER] & ivec_in_loader & ~from_ldr) |
                    (~s_ff.locks[bfg_pkg::LK_LDR_UPPER] & ~ivec_in_loader & from_ldr);
    // fuse is sampled once after reset release; no write path exists
    if (~s_ff.fuse_seen) begin
      nxt_s.fuse_seen = 1'b1;
      nxt_s.rst_vec = reset_vector_select_fuse ? bfg_pkg::APP_RESET_VECTOR
                                               : LOADER_START;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
      s_ff.st <= bfg_pkg::BFG_IDLE;
      s_ff.locks <= bfg_pkg::LOCK_RESET;
      s_ff.stall_ok <= 1'b1;
      s_ff.rst_vec <= bfg_pkg::APP_RESET_VECTOR;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from the state register
  // ----------------------------------------------------------------
  assign prdata = s_ff.rdata;
  assign pready = s_ff.rdy;
  assign pslverr = s_ff.err;
  assign cpu_halt = s_ff.halt;
  assign concurrent_read_ok = ~s_ff.region_busy;
  assign stalling_read_ok = s_ff.stall_ok;
  assign flash_op_start = s_ff.op_start;
  assign flash_op_kind = s_ff.op_kind;
  assign flash_op_page_addr = s_ff.op_page;
  assign load_valid = s_ff.ld_valid;
  assign load_grant = s_ff.ld_grant;
  assign load_byte_addr = s_ff.ld_addr;
  assign irq_disable = s_ff.irq_dis;
  assign reset_vector = s_ff.rst_vec;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic idle_w;
  logic [3:0] locks_w;
  assign idle_w = s_ff.st == bfg_pkg::BFG_IDLE;
  assign locks_w = s_ff.locks;

  chk_stall_halts: assert property (
    (s_ff.st == bfg_pkg::BFG_BUSY) && s_ff.op_stall |-> cpu_halt && !stalling_read_ok
  ) else $error("stalling-region op without halt");

  chk_concurrent_runs: assert property (
    flash_op_start && (flash_op_page_addr < STALL_START) |-> !cpu_halt && stalling_read_ok
  ) else $error("concurrent-region op stalled the cpu");

  chk_store_from_app: assert property (
    flash_store_instr && !from_ldr && !ext_lock_prog && !chip_erase |=>
    !flash_op_start && $stable(locks_w)
  ) else $error("store from application code took effect");

  chk_store_lock: assert property (
    idle_w && flash_store_instr && from_ldr && (s_ff.cmd == bfg_pkg::CMD_ERASE) &&
    st_blocked |=> !flash_op_start && s_ff.blocked
  ) else $error("locked store started an op");

  chk_locks_program: assert property (
    !chip_erase |=> (locks_w & ~$past(locks_w)) == 4'h0
  ) else $error("lock bit returned to one without chip erase");

  chk_page_latched: assert property (
    (s_ff.st == bfg_pkg::BFG_BUSY) && $past(s_ff.st == bfg_pkg::BFG_BUSY) |->
    $stable(flash_op_page_addr)
  ) else $error("page changed during op");

  chk_busy_flag: assert property (
    flash_op_start |-> !concurrent_read_ok ##1 !concurrent_read_ok
  ) else $error("busy flag not set at op start");

  chk_load_byte: assert property (
    load_req |=> load_valid && (load_byte_addr == $past(s_ff.ptr))
  ) else $error("load address not the byte pointer");

  chk_app_load_lock: assert property (
    load_req && !from_ldr && ld_tgt_ldr && !locks_w[bfg_pkg::LK_LDR_UPPER] |=> !load_grant
  ) else $error("application load of locked loader region granted");

  chk_irq_mask: assert property (
    !locks_w[bfg_pkg::LK_APP_UPPER] && ivec_in_loader && !from_ldr |=> irq_disable
  ) else $error("interrupts not masked in application code");

  chk_reset_vec: assert property (
    s_ff.fuse_seen && $rose(s_ff.fuse_seen) |->
    reset_vector == ($past(reset_vector_select_fuse) ? 15'h0000 : LOADER_START)
  ) else $error("reset vector does not follow fuse");

  cov_stall_op: cover property (flash_op_start && cpu_halt);
  cov_concurrent_op: cover property (flash_op_start && !cpu_halt);
  cov_blocked_load: cover property (load_valid && !load_grant);
  cov_lock_set: cover property ($fell(locks_w[bfg_pkg::LK_LDR_LOWER]));

endmodule : bfg_top

`default_nettype wire

// ### dv/bfg_cpu_model.sv
// cpu core model: runs loader or application code, issues store and load pulses
// assumes the guard samples the pulses at the rising pclk edge
`default_nettype none

module bfg_cpu_model (
  input wire logic pclk,
  input wire logic cpu_halt,
  output var logic [14:0] cpu_pc,
  output var logic flash_store_instr,
  output var logic load_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle core at time zero
  initial begin
    cpu_pc = 15'h0000;
    flash_store_instr = 1'b0;
    load_req = 1'b0;
  end

  // move execution to a new word address
  task automatic set_pc(input logic [14:0] pc);
    @(posedge pclk);
    cpu_pc <= pc;
  endtask : set_pc

  // one store instruction; a halted core executes nothing
  task automatic store(input logic [14:0] pc);
    int n;
    n = 0;
    while (cpu_halt !== 1'b0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
    cpu_pc <= pc;
    flash_store_instr <= 1'b1;
    @(posedge pclk);
    flash_store_instr <= 1'b0;
  endtask : store

  // one program-memory load from code at pc
  task automatic load(input logic [14:0] pc);
    @(posedge pclk);
    cpu_pc <= pc;
    load_req <= 1'b1;
    @(posedge pclk);
    load_req <= 1'b0;
  endtask : load
endmodule : bfg_cpu_model

`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the boot flash access guard
// assumes a 10-cycle programming time and the package register map
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, ivec_in_loader, fuse, ext_prog, chip_erase;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] ext_data;
  logic pready, pslverr, cpu_halt, crd_ok, srd_ok, op_start, load_valid, load_grant, irq_dis;
  logic flash_store_instr, load_req, err;
  logic [1:0] op_kind;
  logic [14:0] cpu_pc, page_addr, reset_vector;
  logic [15:0] byte_addr;
  int error_cnt = 0;
  int num_checks = 0;

  bfg_top #(.PROG_TIME_NS(80)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_pc(cpu_pc), .flash_store_instr(flash_store_instr),
    .load_req(load_req), .ivec_in_loader(ivec_in_loader), .reset_vector_select_fuse(fuse),
    .ext_lock_prog(ext_prog), .ext_lock_data(ext_data), .chip_erase(chip_erase),
    .cpu_halt(cpu_halt), .concurrent_read_ok(crd_ok), .stalling_read_ok(srd_ok),
    .flash_op_start(op_start), .flash_op_kind(op_kind), .flash_op_page_addr(page_addr),
    .load_valid(load_valid), .load_grant(load_grant), .load_byte_addr(byte_addr),
    .irq_disable(irq_dis), .reset_vector(reset_vector));

  bfg_cpu_model cpu (.pclk(pclk), .cpu_halt(cpu_halt), .cpu_pc(cpu_pc),
    .flash_store_instr(flash_store_instr), .load_req(load_req));

  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // apb transfer held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // pready, prdata and pslverr as sampled at this rising edge
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED apb_pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // arm a command and run the store from code at pc
  task automatic op(input logic [1:0] cmd, input logic [15:0] ptr, input logic [14:0] pc);
    apb(1'b1, bfg_pkg::OFF_POINTER, {16'h0000, ptr});
    apb(1'b1, bfg_pkg::OFF_CMD, {30'h0, cmd});
    cpu.store(pc);
    #1;
  endtask : op

  // let a running op finish, then clear the busy flag
  task automatic finish_op();
    repeat (12) @(posedge pclk);
    #1;
    chk("halt_end", 32'h0, cpu_halt);
    chk("stall_rd_end", 32'h1, srd_ok);
    apb(1'b1, bfg_pkg::OFF_CMD, 32'h10);
    #1;
    chk("conc_rd_resume", 32'h1, crd_ok);
  endtask : finish_op

  task automatic load_chk(input logic [14:0] pc, input logic [15:0] ptr, input logic g);
    apb(1'b1, bfg_pkg::OFF_POINTER, {16'h0000, ptr});
    cpu.load(pc);
    #1;
    chk("load_valid", 32'h1, load_valid);
    chk("load_grant", {31'h0, g}, load_grant);
    chk("load_addr", {16'h0, ptr}, byte_addr);
  endtask : load_chk

  task automatic do_reset(input logic f);
    @(posedge pclk);
    fuse <= f;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    chk("reset_vector", f ? 32'h0 : 32'h1c00, reset_vector);
  endtask : do_reset

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // erase in the concurrent region; pointer rewritten mid-op
  task automatic t_concurrent();
    op(bfg_pkg::CMD_ERASE, 16'h0156, 15'h1c10);
    chk("op_start", 32'h1, op_start);
    chk("op_kind", 32'h1, op_kind);
    chk("page", 32'h0080, page_addr);
    chk("halt", 32'h0, cpu_halt);
    chk("stall_rd", 32'h1, srd_ok);
    chk("conc_rd", 32'h0, crd_ok);
    apb(1'b1, bfg_pkg::OFF_POINTER, 32'h3f00);
    chk("page_held", 32'h0080, page_addr);
    load_chk(15'h1c10, 16'h3801, 1'b1);
    load_chk(15'h1c10, 16'h0101, 1'b0);
    finish_op();
  endtask : t_concurrent

  // write into the stalling region; same page as a prior erase
  task automatic t_stalling();
    op(bfg_pkg::CMD_ERASE, 16'h3956, 15'h1c10);
    chk("erase_page", 32'h1c80, page_addr);
    finish_op();
    op(bfg_pkg::CMD_WRITE, 16'h3956, 15'h1c10);
    chk("op_start", 32'h1, op_start);
    chk("op_kind", 32'h2, op_kind);
    chk("page", 32'h1c80, page_addr);
    chk("halt", 32'h1, cpu_halt);
    chk("stall_rd", 32'h0, srd_ok);
    // halt stands for exactly ten cycles
    repeat (9) @(posedge pclk);
    #1;
    chk("halt_hold", 32'h1, cpu_halt);
    @(posedge pclk);
    #1;
    chk("halt_drop", 32'h0, cpu_halt);
    finish_op();
  endtask : t_stalling

  // store from application code starts nothing
  task automatic t_app_store();
    op(bfg_pkg::CMD_ERASE, 16'h0100, 15'h0010);
    chk("op_start_app", 32'h0, op_start);
    chk("irq_dis_free", 32'h0, irq_dis);
    apb(1'b1, bfg_pkg::OFF_CMD, 32'h0);
  endtask : t_app_store

  // application lock modes set by software, pointer junk
  task automatic t_app_locks();
    apb(1'b1, bfg_pkg::OFF_LOCK_DATA, 32'he);
    op(bfg_pkg::CMD_LOCK, 16'hffff, 15'h1c00);
    apb(1'b0, bfg_pkg::OFF_LOCKS, 32'h0);
    chk("locks", 32'he, rd[3:0]);
    op(bfg_pkg::CMD_ERASE, 16'h0100, 15'h1c10);
    chk("op_start_lock", 32'h0, op_start);
    apb(1'b0, bfg_pkg::OFF_STATUS, 32'h0);
    chk("blocked", 32'h1, rd[3]);
    chk("no_fault", 32'h0, err);
    load_chk(15'h1c10, 16'h0101, 1'b1);
    apb(1'b1, bfg_pkg::OFF_LOCK_DATA, 32'hc);
    op(bfg_pkg::CMD_LOCK, 16'h0000, 15'h1c00);
    load_chk(15'h1c10, 16'h0101, 1'b0);
    @(posedge pclk);
    ivec_in_loader <= 1'b1;
    cpu.set_pc(15'h0020);
    repeat (2) @(posedge pclk);
    #1;
    chk("irq_dis_app", 32'h1, irq_dis);
  endtask : t_app_locks

  // loader lock modes set from the external port
  task automatic t_loader_locks();
    @(posedge pclk);
    chip_erase <= 1'b1;
    @(posedge pclk);
    chip_erase <= 1'b0;
    apb(1'b0, bfg_pkg::OFF_LOCKS, 32'h0);
    chk("locks_erased", 32'hf, rd[3:0]);
    @(posedge pclk);
    ext_prog <= 1'b1;
    ext_data <= 4'h7;
    @(posedge pclk);
    ext_prog <= 1'b0;
    load_chk(15'h0010, 16'h3801, 1'b0);
    load_chk(15'h1c10, 16'h3801, 1'b1);
    @(posedge pclk);
    ivec_in_loader <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk("irq_dis_ldr", 32'h1, irq_dis);
    op(bfg_pkg::CMD_WRITE, 16'h3880, 15'h1c10);
    chk("op_start_ldr", 32'h1, op_start);
    finish_op();
    @(posedge pclk);
    ext_prog <= 1'b1;
    ext_data <= 4'h3;
    @(posedge pclk);
    ext_prog <= 1'b0;
    op(bfg_pkg::CMD_ERASE, 16'h3880, 15'h1c10);
    chk("op_start_ldr_lk", 32'h0, op_start);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", 32'h1, err);
  endtask : t_loader_locks

  // app lock 0,1 and loader lock 1,0 from the external port
  task automatic t_mid_locks();
    @(posedge pclk);
    chip_erase <= 1'b1;
    @(posedge pclk);
    chip_erase <= 1'b0;
    ext_prog <= 1'b1;
    ext_data <= 4'h9;
    @(posedge pclk);
    ext_prog <= 1'b0;
    op(bfg_pkg::CMD_ERASE, 16'h0100, 15'h1c10);
    chk("op_start_app_ok", 32'h1, op_start);
    finish_op();
    load_chk(15'h1c10, 16'h0101, 1'b0);
    op(bfg_pkg::CMD_ERASE, 16'h3880, 15'h1c10);
    chk("op_start_ldr_st", 32'h0, op_start);
    load_chk(15'h0010, 16'h3801, 1'b1);
  endtask : t_mid_locks

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ivec_in_loader = 1'b0;
    fuse = 1'b1;
    ext_prog = 1'b0;
    ext_data = 4'hf;
    chip_erase = 1'b0;
    do_reset(1'b1);
    t_concurrent();
    t_stalling();
    t_app_store();
    t_app_locks();
    t_loader_locks();
    t_mid_locks();
    do_reset(1'b0);
    stop_test();
  end

  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
endmodule : tb

`default_nettype wire
